// ---- hdl/cttb_pkg.sv ----
package cttb_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTTB_CTRL_OFS = 8'h00;
  localparam logic [7:0] CTTB_TEMP_OFS = 8'h04;
  localparam logic [7:0] CTTB_BYP_OFS  = 8'h08;
  localparam logic [7:0] CTTB_STAT_OFS = 8'h0c;

  // control register fields
  localparam int CTRL_CHG_EN_B   = 0;
  localparam int CTRL_TMR_EN_B   = 1;
  localparam int CTRL_SLOW_EN_B  = 2;
  localparam int CTRL_PRE_EN_B   = 3;
  localparam int CTRL_FAST_SEL_B = 4;
  localparam int CTRL_PRE_SEL_B  = 6;
  localparam int CTRL_CV_SEL_B   = 8;
  localparam int CTRL_CV_MASK_B  = 11;
  localparam logic [11:0] CTRL_RST = 12'h06f;

  // temperature profile fields
  localparam int TEMP_TS_EN_B    = 0;
  localparam int TEMP_PROF_EN_B  = 1;
  localparam int TEMP_COOL_SEL_B = 2;
  localparam int TEMP_WARM_V_B   = 4;
  localparam int TEMP_WARM_I_B   = 6;
  localparam logic [7:0] TEMP_RST = 8'h9b;

  // passthrough fields
  localparam int BYP_PT_EN_B   = 0;
  localparam int BYP_EXT_EN_B  = 1;
  localparam int BYP_LL_EN_B   = 2;
  localparam int BYP_MASK_B    = 3;
  localparam logic [3:0] BYP_RST = 4'h4;

  // status fields
  localparam int STAT_TMR_FLT_B = 0;
  localparam int STAT_PRE_FLT_B = 1;
  localparam int STAT_CV_DONE_B = 2;
  localparam int STAT_BYP_FLG_B = 3;
  localparam int STAT_TS_B      = 4;
  localparam int STAT_BYP_ACT_B = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // one tick per second: timers count half seconds, two per tick (one for a slowed fast timer)
  localparam int TICK_NS       = 1_000_000_000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int BYP_OCP_NS    = 100_000;
  localparam int BYP_OCP_CYC   = BYP_OCP_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_H   = 7200;
  localparam int PRE_SHORT_MIN = 30;
  localparam int PRE_LONG_H    = 2;
  localparam int FAST_H0       = 5;
  localparam int FAST_H1       = 8;
  localparam int FAST_H2       = 12;
  localparam int FAST_H3       = 20;

  typedef enum logic [2:0] {TS_NORMAL, TS_COOL, TS_WARM, TS_COLD, TS_HOT} cttb_temp_e;
  typedef enum logic [1:0] {ISC_FULL, ISC_40, ISC_20} cttb_iscale_e;

  typedef struct packed {
    logic charge_enable_n;
    logic input_voltage_limit_status;
    logic input_current_limit_status;
    logic thermal_reg_status;
    logic charge_fault;
    logic vbat_below_lowv;
    logic cv_mode;
    logic ts_cold;
    logic ts_cool;
    logic ts_warm;
    logic ts_hot;
    logic reverse_mode;
    logic ts_rev_cold;
    logic ts_rev_hot;
    logic bypass_ocp;
    logic ext_bypass_ocp;
    logic light_load;
  } cttb_sense_s;

endpackage

// ---- hdl/cttb_ctrl.sv ----
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module cttb_ctrl #(
  parameter int TICK_CYC    = cttb_pkg::TICK_CYC,
  parameter int BYP_OCP_CYC = cttb_pkg::BYP_OCP_CYC
) (
  input  wire logic                 sys_clk_i,               // 250 MHz
  input  wire logic                 rst_n_i,                 // sync, low
  input  wire logic                 psel_i,                  // apb select
  input  wire logic                 penable_i,               // apb enable
  input  wire logic                 pwrite_i,                // apb write
  input  wire logic [7:0]           paddr_i,                 // byte address
  input  wire logic [31:0]          pwdata_i,                // write data
  output logic      [31:0]          prdata_o,                // read data
  output logic                      pready_o,                // always ready
  output logic                      pslverr_o,               // unmapped
  input  wire cttb_pkg::cttb_sense_s sense_i,                // async sense
  output logic                      irq_pulse_o,             // event pulse
  output logic                      charge_allow_o,          // charge on
  output cttb_pkg::cttb_iscale_e    current_scale_o,         // current
  output logic      [1:0]           vreg_offset_o,           // volt offset
  output cttb_pkg::cttb_temp_e      temperature_status_o,    // zone
  output logic                      reverse_suspend_o,       // stop switch
  output logic                      internal_regulator_on_o, // keep on
  output logic                      internal_bypass_o,       // q1/q4 on
  output logic                      external_switch_drive_o  // ext fets
);
  import cttb_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = $bits(cttb_sense_s);
  logic [SW-1:0] s1_r, s2_r, s3_r, sen_r;
  cttb_sense_s   sn;

  // a bit changes only once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      sen_r <= '0;
    end else begin
      s1_r  <= sense_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      sen_r <= (s2_r & s3_r) | (sen_r & (s2_r | s3_r));
    end
  end
  assign sn = cttb_sense_s'(sen_r);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [11:0] ctrl_r;
  logic [7:0]  temp_r;
  logic [3:0]  byp_r;
  logic        tmr_flt_r, pre_flt_r, cv_done_r, byp_flg_r;
  logic        wr_en, rd_setup, hit;
  cttb_temp_e  temperature_status;
  logic        byp_exit;

  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign hit      = (paddr_i == CTTB_CTRL_OFS) | (paddr_i == CTTB_TEMP_OFS) |
                    (paddr_i == CTTB_BYP_OFS)  | (paddr_i == CTTB_STAT_OFS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
      temp_r <= TEMP_RST;
    end else if (wr_en) begin
      if (paddr_i == CTTB_CTRL_OFS) ctrl_r <= pwdata_i[11:0];
      if (paddr_i == CTTB_TEMP_OFS) temp_r <= pwdata_i[7:0];
    end
  end

  // a hardware exit beats a same-cycle software write of the enable
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      byp_r <= BYP_RST;
    end else begin
      if (wr_en && paddr_i == CTTB_BYP_OFS) byp_r <= pwdata_i[3:0];
      if (byp_exit) byp_r[BYP_PT_EN_B] <= 1'b0;
    end
  end

  // read data captured in setup, zero wait answer in access
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (rd_setup) begin
      unique case (paddr_i)
        CTTB_CTRL_OFS: prdata_o <= {20'h0, ctrl_r};
        CTTB_TEMP_OFS: prdata_o <= {24'h0, temp_r};
        CTTB_BYP_OFS:  prdata_o <= {28'h0, byp_r};
        CTTB_STAT_OFS: prdata_o <= {24'h0, internal_bypass_o | external_switch_drive_o,
                                     temperature_status, byp_flg_r, cv_done_r, pre_flt_r, tmr_flt_r};
        default:       prdata_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // temperature qualification
  // ---------------------------------------------------------------
  logic         ts_en, prof_en, temp_susp;
  logic [1:0]   cool_sel, warm_v, warm_i;
  cttb_iscale_e iscale;
  logic [1:0]   voff;

  assign ts_en    = temp_r[TEMP_TS_EN_B];
  assign prof_en  = temp_r[TEMP_PROF_EN_B];
  assign cool_sel = temp_r[TEMP_COOL_SEL_B +: 2];
  assign warm_v   = temp_r[TEMP_WARM_V_B +: 2];
  assign warm_i   = temp_r[TEMP_WARM_I_B +: 2];

  always_comb begin
    temperature_status = TS_NORMAL;
    if (!ts_en) begin
      temperature_status = TS_NORMAL;
    end else if (sn.reverse_mode) begin
      if (sn.ts_rev_cold) temperature_status = TS_COLD;
      else if (sn.ts_rev_hot) temperature_status = TS_HOT;
    end else if (sn.ts_cold) begin
      temperature_status = TS_COLD;
    end else if (sn.ts_hot) begin
      temperature_status = TS_HOT;
    end else if (sn.ts_cool) begin
      temperature_status = TS_COOL;
    end else if (sn.ts_warm) begin
      temperature_status = TS_WARM;
    end
  end

  always_comb begin
    temp_susp = 1'b0;
    iscale    = ISC_FULL;
    voff      = 2'h0;
    if (!sn.reverse_mode) begin
      if (temperature_status == TS_COLD || temperature_status == TS_HOT) temp_susp = 1'b1;
      if (prof_en && temperature_status == TS_COOL) begin
        if (cool_sel == 2'h0) temp_susp = 1'b1;
        else if (cool_sel == 2'h1) iscale = ISC_20;
        else if (cool_sel == 2'h2) iscale = ISC_40;
      end
      if (prof_en && temperature_status == TS_WARM) begin
        if (warm_v == 2'h0) temp_susp = 1'b1;
        voff = warm_v;
        if (warm_i == 2'h0) temp_susp = 1'b1;
        else if (warm_i == 2'h1) iscale = ISC_40;
      end
    end
  end

  // ---------------------------------------------------------------
  // safety, pre-charge and cv timers (half-second units, two per tick, one when the safety timer is slowed)
  // ---------------------------------------------------------------
  function automatic logic [17:0] hrs2t(input int h);
    return 18'(h * TICKS_PER_H);
  endfunction

  logic [31:0] tick_cnt_r;
  logic        tick, chg_on, run, slow, fast_evt, pre_evt, cv_evt, cv_run;
  logic [17:0] fast_cnt_r, pre_cnt_r, cv_cnt_r, fast_lim, pre_lim, cv_lim;
  logic [2:0]  cv_sel;

  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || tick) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  assign chg_on = ctrl_r[CTRL_CHG_EN_B] & ~sn.charge_enable_n;
  assign run    = chg_on & ~sn.charge_fault & ~temp_susp;
  assign slow   = ctrl_r[CTRL_SLOW_EN_B] & (sn.input_voltage_limit_status |
                  sn.input_current_limit_status | sn.thermal_reg_status);
  assign cv_sel = ctrl_r[CTRL_CV_SEL_B +: 3];

  always_comb begin
    unique case (ctrl_r[CTRL_FAST_SEL_B +: 2])
      2'h0: fast_lim = hrs2t(FAST_H0);
      2'h1: fast_lim = hrs2t(FAST_H1);
      2'h2: fast_lim = hrs2t(FAST_H2);
      2'h3: fast_lim = hrs2t(FAST_H3);
    endcase
  end
  assign pre_lim = ctrl_r[CTRL_PRE_SEL_B] ? hrs2t(PRE_LONG_H)
                                          : 18'(PRE_SHORT_MIN * TICKS_PER_H / 60);
  assign cv_lim  = hrs2t(int'(cv_sel));

  assign fast_evt = chg_on & ctrl_r[CTRL_TMR_EN_B] & ~tmr_flt_r & (fast_cnt_r >= fast_lim);
  assign pre_evt  = chg_on & ctrl_r[CTRL_PRE_EN_B] & ~pre_flt_r & (pre_cnt_r >= pre_lim);
  assign cv_evt   = chg_on & (cv_sel != 3'h0) & ~cv_done_r & (cv_cnt_r >= cv_lim);
  assign cv_run   = run & sn.cv_mode & ~sn.input_current_limit_status &
                    ~sn.input_voltage_limit_status;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !chg_on) begin
      fast_cnt_r <= '0;
    end else if (ctrl_r[CTRL_TMR_EN_B] && run && !sn.vbat_below_lowv &&
                 !tmr_flt_r && tick) begin
      fast_cnt_r <= fast_cnt_r + (slow ? 18'h1 : 18'h2);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !chg_on || !ctrl_r[CTRL_PRE_EN_B]) begin
      pre_cnt_r <= '0;
    end else if (run && sn.vbat_below_lowv && !pre_flt_r && tick) begin
      pre_cnt_r <= pre_cnt_r + 18'h2;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !chg_on || cv_sel == 3'h0) begin
      cv_cnt_r <= '0;
    end else if (cv_run && !cv_done_r && tick) begin
      cv_cnt_r <= cv_cnt_r + 18'h2;
    end
  end

  // expiries stick until the charge cycle is restarted
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !chg_on) begin
      tmr_flt_r <= 1'b0;
      pre_flt_r <= 1'b0;
      cv_done_r <= 1'b0;
    end else begin
      if (fast_evt) tmr_flt_r <= 1'b1;
      if (pre_evt) pre_flt_r <= 1'b1;
      if (cv_evt) cv_done_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // passthrough supervision
  // ---------------------------------------------------------------
  logic        pt_en, ext_en, ocp, ll_exit;
  logic [31:0] ocp_cnt_r;

  assign pt_en   = byp_r[BYP_PT_EN_B];
  assign ext_en  = byp_r[BYP_EXT_EN_B];
  assign ocp     = pt_en & (ext_en ? sn.ext_bypass_ocp : sn.bypass_ocp);
  assign ll_exit = pt_en & byp_r[BYP_LL_EN_B] & sn.light_load;
  assign byp_exit = ll_exit | (ocp && ocp_cnt_r == 32'(BYP_OCP_CYC - 1));

  // overcurrent must persist the whole filter time
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !ocp || byp_exit) ocp_cnt_r <= '0;
    else ocp_cnt_r <= ocp_cnt_r + 32'h1;
  end

  // flag: the exit event wins over a write-one-to-clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      byp_flg_r <= 1'b0;
    end else if (byp_exit) begin
      byp_flg_r <= 1'b1;
    end else if (wr_en && paddr_i == CTTB_STAT_OFS && pwdata_i[STAT_BYP_FLG_B]) begin
      byp_flg_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_pulse_o             <= 1'b0;
      charge_allow_o          <= 1'b0;
      current_scale_o         <= ISC_FULL;
      vreg_offset_o           <= 2'h0;
      temperature_status_o    <= TS_NORMAL;
      reverse_suspend_o       <= 1'b0;
      internal_regulator_on_o <= 1'b0;
      internal_bypass_o       <= 1'b0;
      external_switch_drive_o <= 1'b0;
    end else begin
      irq_pulse_o <= fast_evt | pre_evt |
                     (cv_evt & ~ctrl_r[CTRL_CV_MASK_B]) |
                     (byp_exit & ~byp_r[BYP_MASK_B]);
      charge_allow_o <= run & ~sn.reverse_mode & ~tmr_flt_r & ~pre_flt_r &
                        ~cv_done_r;
      current_scale_o         <= iscale;
      vreg_offset_o           <= voff;
      temperature_status_o    <= temperature_status;
      reverse_suspend_o       <= sn.reverse_mode &&
                                 (temperature_status == TS_COLD || temperature_status == TS_HOT);
      internal_regulator_on_o <= sn.reverse_mode;
      internal_bypass_o       <= pt_en & ~ext_en & ~byp_exit;
      external_switch_drive_o <= pt_en & ext_en & ~byp_exit;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  fault_set_a: assert property (fast_evt |=> tmr_flt_r && irq_pulse_o)
    else $error("timer expiry without fault and interrupt");
  timer_off_a: assert property (chg_on && !ctrl_r[CTRL_TMR_EN_B] |=> $stable(fast_cnt_r))
    else $error("fast timer moved while disabled");
  half_rate_a: assert property (tick && run && slow && ctrl_r[CTRL_TMR_EN_B] &&
    !sn.vbat_below_lowv && !tmr_flt_r |=> fast_cnt_r == $past(fast_cnt_r) + 18'h1)
    else $error("fast timer not at half rate");
  fault_hold_a: assert property (chg_on && sn.charge_fault |=>
    $stable(fast_cnt_r) && $stable(pre_cnt_r) && $stable(cv_cnt_r))
    else $error("timers moved during fault");
  restart_clr_a: assert property (!chg_on |=>
    fast_cnt_r == 18'h0 && pre_cnt_r == 18'h0 && cv_cnt_r == 18'h0)
    else $error("timers not cleared on stop");
  pre_window_a: assert property (chg_on && !sn.vbat_below_lowv |=> $stable(pre_cnt_r))
    else $error("pre-charge timer ran above threshold");
  pre_off_a: assert property (!ctrl_r[CTRL_PRE_EN_B] |=> pre_cnt_r == 18'h0 && !pre_evt)
    else $error("pre-charge timer active while disabled");
  cv_off_a: assert property (cv_sel == 3'h0 |=> cv_cnt_r == 18'h0 && !cv_done_r)
    else $error("cv timer active while disabled");
  cv_irq_a: assert property (cv_evt && !ctrl_r[CTRL_CV_MASK_B] |=> irq_pulse_o)
    else $error("cv expiry without interrupt");
  window_a: assert property (!sn.reverse_mode && ts_en &&
    (sn.ts_cold || sn.ts_hot) |=> !charge_allow_o)
    else $error("charging outside the window");
  byp_exit_a: assert property (byp_exit |=> !pt_en && byp_flg_r &&
    $stable(ext_en) ##1 !internal_bypass_o && !external_switch_drive_o)
    else $error("bypass exit not carried out");
  ext_gate_a: assert property (external_switch_drive_o |-> $past(pt_en && ext_en))
    else $error("external drive without both enables");

  fast_exp_c: cover property (fast_evt ##1 irq_pulse_o);
  cv_exp_c:   cover property (cv_evt);
  ocp_exit_c: cover property (ocp && byp_exit);
  ll_exit_c:  cover property (ll_exit && ext_en);

endmodule

// ---- dv/cttb_host.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side: apb master, zero-delay requests after the clock edge
// ---------------------------------------------------------------
module cttb_host (
  input  wire logic        sys_clk_i, // bus clock
  output logic             psel_o,    // select
  output logic             penable_o, // access phase
  output logic             pwrite_o,  // direction
  output logic [7:0]       paddr_o,   // byte address
  output logic [31:0]      pwdata_o,  // write data
  input  wire logic [31:0] prdata_i,  // read data
  input  wire logic        pready_i,  // slave ready
  input  wire logic        pslverr_i  // slave error
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    do @(posedge sys_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines carry junk, never the last value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// ---- dv/test_charge_timer_temp_bypass_ctrl.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_charge_timer_temp_bypass_ctrl;
  import cttb_pkg::*;
  localparam int TK = 2;
  localparam int OC = 8;
  // full-rate 5 h fast timer plus the 2003 cycles it is held disabled
  localparam int FT = FAST_H0 * TICKS_PER_H / 2 * TK + 2003;
  logic         sys_clk_i, rst_n_i, psel, pen, pwr, prdy, perr, er;
  logic [7:0]   pa, t;
  logic [31:0]  pwd, prd, rd;
  logic         irq, allow, rsus, rreg, ib, ext;
  logic [1:0]   vo;
  cttb_sense_s  sn;
  cttb_iscale_e sc;
  cttb_temp_e   ts;
  int           n_errors = 0, checks_done = 0, seed = 59, irq_cnt = 0, i0, t1, t2, t3, t4, t5;
  logic [7:0]   corner [8] = '{8'h9b, 8'h02, 8'h01, 8'h03, 8'h57, 8'h6b, 8'hcf, 8'ha7};

  cttb_ctrl #(.TICK_CYC(TK), .BYP_OCP_CYC(OC)) cttb_ctrl_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .sense_i(sn),
    .irq_pulse_o(irq), .charge_allow_o(allow), .current_scale_o(sc), .vreg_offset_o(vo),
    .temperature_status_o(ts), .reverse_suspend_o(rsus), .internal_regulator_on_o(rreg),
    .internal_bypass_o(ib), .external_switch_drive_o(ext));
  cttb_host cttb_host_inst (.sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy),
    .pslverr_i(perr));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (irq === 1'b1) irq_cnt++;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cttb_host_inst.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdr(input logic [7:0] a);
    cttb_host_inst.xfer(1'b0, a, 32'h0, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    `CHK(rd, e)
  endtask
  task automatic settle;
    repeat (8) @(posedge sys_clk_i);
  endtask
  // {allow, scale, offset, zone}; scale and offset only matter while allowed
  function automatic logic [7:0] texp(input logic [7:0] c, input int z);
    logic a;
    logic [1:0] s, v;
    a = (z < 3);
    s = ISC_FULL;
    v = 2'h0;
    if (c[0] == 1'b0) return {1'b1, ISC_FULL, 2'h0, TS_NORMAL};
    if (c[1] && z == 1) begin
      a = (c[3:2] != 2'h0);
      s = (c[3:2] == 2'h1) ? ISC_20 : (c[3:2] == 2'h2) ? ISC_40 : ISC_FULL;
    end
    if (c[1] && z == 2) begin
      a = (c[5:4] != 2'h0) && (c[7:6] != 2'h0);
      s = (c[7:6] == 2'h1) ? ISC_40 : ISC_FULL;
      v = c[5:4];
    end
    return {a, s, v, 3'(z)};
  endfunction
  // restart the cycle, then time the next interrupt
  task automatic run(input logic [11:0] c, output int n);
    wr(CTTB_CTRL_OFS, {20'h0, c & 12'hffe});
    wr(CTTB_CTRL_OFS, {20'h0, c});
    rdr(CTTB_STAT_OFS);
    `CHK(rd[2:0], 3'h0)
    n = 0;
    i0 = irq_cnt;
    while (irq_cnt == i0 && n < 40000) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  initial begin
    // long timer runs dominate: about 80000 cycles expected
    repeat (100000) @(posedge sys_clk_i);
    n_errors++;
    end_sim;
  end

  initial begin
    sn = '0;
    rst_n_i = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle;
    rdc(CTTB_CTRL_OFS, {20'h0, CTRL_RST});
    rdc(CTTB_TEMP_OFS, {24'h0, TEMP_RST});
    rdc(CTTB_BYP_OFS, {28'h0, BYP_RST});
    rdc(8'h10, 32'h0);
    `CHK(er, 1'b1)
    wr(CTTB_STAT_OFS, 32'hf7);
    rdr(CTTB_STAT_OFS);
    `CHK(rd[2:0], 3'h0)
    $display("test registers done");
    for (int k = 0; k < 14; k++) begin
      t = (k < 8) ? corner[k] : 8'($random(seed));
      wr(CTTB_TEMP_OFS, {24'h0, t});
      rdc(CTTB_TEMP_OFS, {24'h0, t});
      for (int z = 0; z < 5; z++) begin
        sn.ts_cool <= (z == 1);
        sn.ts_warm <= (z == 2);
        sn.ts_cold <= (z == 3);
        sn.ts_hot <= (z == 4);
        settle;
        if (texp(t, z) >= 8'h80) `CHK({allow, sc, vo, ts}, texp(t, z))
        else `CHK({allow, ts}, {1'b0, 3'(texp(t, z))})
      end
    end
    sn.ts_hot <= 1'b0;
    $display("test temperature done");
    wr(CTTB_TEMP_OFS, {24'h0, TEMP_RST});
    sn.reverse_mode <= 1'b1;
    sn.ts_rev_hot <= 1'b1;
    settle;
    `CHK({rsus, rreg, ts}, {2'b11, TS_HOT})
    sn.ts_rev_hot <= 1'b0;
    settle;
    `CHK({rsus, rreg, ts}, {2'b01, TS_NORMAL})
    wr(CTTB_TEMP_OFS, 32'h9a);
    sn.ts_rev_cold <= 1'b1;
    settle;
    `CHK({rsus, ts}, {1'b0, TS_NORMAL})
    sn.ts_rev_cold <= 1'b0;
    sn.reverse_mode <= 1'b0;
    wr(CTTB_TEMP_OFS, {24'h0, TEMP_RST});
    $display("test reverse done");
    wr(CTTB_BYP_OFS, 32'h1);
    settle;
    `CHK({ib, ext}, 2'b10)
    wr(CTTB_BYP_OFS, 32'h3);
    settle;
    `CHK({ib, ext}, 2'b01)
    sn.ext_bypass_ocp <= 1'b1;
    repeat (OC / 2) @(posedge sys_clk_i);
    sn.ext_bypass_ocp <= 1'b0;
    settle;
    `CHK(ext, 1'b1)
    i0 = irq_cnt;
    sn.ext_bypass_ocp <= 1'b1;
    repeat (OC + 8) @(posedge sys_clk_i);
    sn.ext_bypass_ocp <= 1'b0;
    settle;
    `CHK(ext, 1'b0)
    rdc(CTTB_BYP_OFS, 32'h2);
    `CHK(irq_cnt - i0, 1)
    rdr(CTTB_STAT_OFS);
    `CHK(rd[3], 1'b1)
    wr(CTTB_STAT_OFS, 32'h8);
    rdr(CTTB_STAT_OFS);
    `CHK(rd[3], 1'b0)
    wr(CTTB_BYP_OFS, 32'h9);
    i0 = irq_cnt;
    sn.bypass_ocp <= 1'b1;
    repeat (OC + 8) @(posedge sys_clk_i);
    sn.bypass_ocp <= 1'b0;
    settle;
    rdc(CTTB_BYP_OFS, 32'h8);
    `CHK({ib, irq_cnt == i0}, 2'b01)
    wr(CTTB_STAT_OFS, 32'h8);
    wr(CTTB_BYP_OFS, 32'h5);
    settle;
    i0 = irq_cnt;
    sn.light_load <= 1'b1;
    settle;
    rdc(CTTB_BYP_OFS, 32'h4);
    `CHK(irq_cnt - i0, 1)
    wr(CTTB_BYP_OFS, 32'h1);
    settle;
    `CHK(ib, 1'b1)
    sn.light_load <= 1'b0;
    wr(CTTB_BYP_OFS, 32'h0);
    $display("test passthrough done");
    sn.vbat_below_lowv <= 1'b1;
    wr(CTTB_CTRL_OFS, 32'h027);
    i0 = irq_cnt;
    repeat (7600) @(posedge sys_clk_i);
    rdr(CTTB_STAT_OFS);
    `CHK({rd[1], irq_cnt == i0}, 2'b01)
    run(12'h02f, t1);
    rdr(CTTB_STAT_OFS);
    `CHK(rd[1], 1'b1)
    sn.input_current_limit_status <= 1'b1;
    run(12'h02f, t2);
    `CHK(t2 >= t1 - TK && t2 <= t1 + TK, 1'b1)
    sn.input_current_limit_status <= 1'b0;
    run(12'h06f, t3);
    `CHK(t3 >= 4 * t1 - 6 * TK && t3 <= 4 * t1 + 6 * TK, 1'b1)
    $display("test precharge done");
    sn.vbat_below_lowv <= 1'b0;
    sn.cv_mode <= 1'b1;
    sn.thermal_reg_status <= 1'b1;
    // a fault, then current limiting, pause the cv timer for 1500 cycles
    fork
      run(12'h16f, t4);
      begin
        repeat (3000) @(posedge sys_clk_i);
        sn.charge_fault <= 1'b1;
        repeat (1000) @(posedge sys_clk_i);
        `CHK(allow, 1'b0)
        sn.charge_fault <= 1'b0;
        sn.input_current_limit_status <= 1'b1;
        repeat (500) @(posedge sys_clk_i);
        sn.input_current_limit_status <= 1'b0;
      end
    join
    `CHK(t4 >= 2*t1 + 1500 - 3*TK && t4 <= 2*t1 + 1500 + 3*TK, 1'b1)
    rdr(CTTB_STAT_OFS);
    `CHK(rd[2], 1'b1)
    $display("test cv timer done");
    // full rate despite regulation, slow count off; held while disabled
    fork
      run(12'h00b, t5);
      begin
        repeat (10000) @(posedge sys_clk_i);
        wr(CTTB_CTRL_OFS, 32'h009);
        repeat (2000) @(posedge sys_clk_i);
        wr(CTTB_CTRL_OFS, 32'h00b);
      end
    join
    `CHK(t5 >= FT - 2*TK && t5 <= FT + TK, 1'b1)
    rdr(CTTB_STAT_OFS);
    `CHK(rd[0], 1'b1)
    $display("test safety timer done");
    end_sim;
  end
endmodule
